// [rtl/ssl_pkg.sv]
// Shared constants for the strap sampling and status indicator block.
package ssl_pkg;
   // Number of multi-function strap pins and their positions in the pad vectors.
   localparam int STRAP_W = 3;
   localparam int PIN_MODE_COL = 0;
   localparam int PIN_ADDR2_LINK = 1;
   localparam int PIN_ADDR3_TX = 2;

   // Clock rate and collision hold time.
   localparam longint CLK_HZ = 125000000;
   localparam longint COL_HOLD_MS = 70;
   localparam int COL_HOLD_CYC = int'((CLK_HZ * COL_HOLD_MS) / 1000);

   // Register bus layout, byte addresses of 32-bit words.
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h4;

   // Status register fields.
   localparam int ST_MODE_STRAP = 0;
   localparam int ST_ADDR2 = 1;
   localparam int ST_ADDR3 = 2;
   localparam int ST_SPEED = 3;
   localparam int ST_COL_LED = 4;
   localparam int ST_LINK = 5;
   localparam int ST_DRIVING = 6;

   // Control register fields and reset value.
   localparam int CT_SOFT_RESET = 0;
   localparam int CT_LED_OFF = 1;
   localparam logic [31:0] CONTROL_RST = 32'h0000_0000;

   // Pin sequencing states.
   typedef enum logic [1:0] {
      SEQ_RESET = 2'b00,
      SEQ_CAPTURE = 2'b01,
      SEQ_DRIVE = 2'b10
   } ssl_seq_t;
endpackage : ssl_pkg

// [rtl/ssl_stretch.sv]
// Retriggerable pulse stretcher that holds the collision indicator on.
`timescale 1ns/1ps
`default_nettype none
module ssl_stretch #(
   parameter int HOLD_CYC = 8750000
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clear,
   input wire logic trigger,
   output logic active
);
   localparam int CNT_W = $clog2(HOLD_CYC + 1);
   localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYC);

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic active_r;
   logic active_nxt;

   // A fresh event reloads the count, so it wins over a clear in the same cycle.
   always_comb begin
      cnt_nxt = cnt_r;
      if (trigger) begin
         cnt_nxt = HOLD_LOAD;
      end else if (clear) begin
         cnt_nxt = '0;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - CNT_W'(1);
      end
      active_nxt = (cnt_nxt != '0);
   end

   // Counter and indicator registers.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cnt_r <= '0;
         active_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         active_r <= active_nxt;
      end
   end

   assign active = active_r;
endmodule : ssl_stretch
`default_nettype wire

// [rtl/ssl_strap_led.sv]
// Strap sampling, interface mode selection and status LED drive for three shared pins.
//
// Behaviour
// - Each strap pin is an input during hardware reset and becomes a status output after it.
// - A low interface-mode strap selects the standard media-independent interface at the selected speed.
// - A high interface-mode strap selects the serial interface at 10M or the symbol interface at 100M.
// - After reset the interface-mode pin shows collision, asserted on collision and deasserted otherwise.
// - A detected collision keeps the collision indicator asserted for about 70 ms.
// - Station address bit 2 is loaded from the link pin level during reset, low for zero, high for one.
// - After reset the link pin is asserted while the link is valid and deasserted without link.
// - Station address bit 3 is loaded from the transmit pin level during reset, low for zero, high for one.
// - After reset the transmit pin is asserted while the link is valid and deasserted without link.
// - Strap levels are captured on leaving hardware reset and kept until the next hardware reset.
// - A software reset neither resamples nor changes the straps, and the pins stay driven during it.
// - A driven strap pin asserts at the inverse of the level sampled on it during reset.
`timescale 1ns/1ps
`default_nettype none
module ssl_strap_led
   import ssl_pkg::*;
#(
   parameter int COL_HOLD = COL_HOLD_CYC
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [STRAP_W-1:0] pad_in,
   output logic [STRAP_W-1:0] pad_out,
   output logic [STRAP_W-1:0] pad_oe,
   input wire logic speed_select,
   input wire logic collision_det,
   input wire logic link_ok,
   output logic iface_mii,
   output logic iface_serial,
   output logic iface_symbol,
   output logic station_addr2,
   output logic station_addr3,
   output logic strap_valid,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   // Pin synchronisers; left without reset so the level is live at reset release.
   logic [STRAP_W-1:0] pad_s1_r;
   logic [STRAP_W-1:0] pad_s2_r;
   logic spd_s1_r;
   logic spd_s2_r;

   logic [STRAP_W-1:0] strap_r;
   logic [STRAP_W-1:0] strap_nxt;
   ssl_seq_t seq_r;
   ssl_seq_t seq_nxt;
   logic [STRAP_W-1:0] oe_r;
   logic [STRAP_W-1:0] oe_nxt;
   logic [STRAP_W-1:0] out_r;
   logic [STRAP_W-1:0] out_nxt;
   logic [STRAP_W-1:0] assert_req;
   logic mii_r;
   logic mii_nxt;
   logic serial_r;
   logic serial_nxt;
   logic symbol_r;
   logic symbol_nxt;
   logic col_active;
   logic [31:0] control_r;
   logic [31:0] control_nxt;
   logic soft_rst_r;
   logic soft_rst_nxt;
   logic wait_r;
   logic wait_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [31:0] status_word;
   logic acc_ok;

   // Two flops ahead of any logic; the first stage is read only by the second.
   always_ff @(posedge clk_sys) begin
      pad_s1_r <= pad_in;
      pad_s2_r <= pad_s1_r;
      spd_s1_r <= speed_select;
      spd_s2_r <= spd_s1_r;
   end

   // Sequencer: undriven during reset, capture once on release, then drive.
   always_comb begin
      seq_nxt = seq_r;
      strap_nxt = strap_r;
      oe_nxt = oe_r;
      unique case (seq_r)
         SEQ_RESET: begin
            seq_nxt = SEQ_CAPTURE;
            oe_nxt = '0;
         end
         SEQ_CAPTURE: begin
            strap_nxt = pad_s2_r;
            oe_nxt = '1;
            seq_nxt = SEQ_DRIVE;
         end
         SEQ_DRIVE: begin
            oe_nxt = '1;
         end
         default: begin
            seq_nxt = SEQ_RESET;
            oe_nxt = '0;
         end
      endcase
   end

   // Only the hardware reset clears the straps; the soft reset never reaches them.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         seq_r <= SEQ_RESET;
         strap_r <= '0;
         oe_r <= '0;
      end else begin
         seq_r <= seq_nxt;
         strap_r <= strap_nxt;
         oe_r <= oe_nxt;
      end
   end

   // Collision hold timer, cleared by soft reset but retriggered by any new event.
   ssl_stretch #(
      .HOLD_CYC(COL_HOLD)
   ) u_col_stretch (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clear(soft_rst_r),
      .trigger(collision_det && (seq_r == SEQ_DRIVE)),
      .active(col_active)
   );

   // Status meaning of each pin before polarity is applied.
   always_comb begin
      assert_req = '0;
      assert_req[PIN_MODE_COL] = col_active;
      assert_req[PIN_ADDR2_LINK] = link_ok;
      assert_req[PIN_ADDR3_TX] = link_ok;
      if (control_r[CT_LED_OFF]) begin
         assert_req = '0;
      end
   end

   // Asserted level is the inverse of the strap, so a series LED lights on either board wiring.
   genvar gi;
   generate
      for (gi = 0; gi < STRAP_W; gi++) begin : g_pin
         assign out_nxt[gi] = assert_req[gi] ? ~strap_nxt[gi] : strap_nxt[gi];
      end
   endgenerate

   // Interface mode from the mode strap and the synchronised speed input.
   always_comb begin
      mii_nxt = 1'b0;
      serial_nxt = 1'b0;
      symbol_nxt = 1'b0;
      if (seq_r == SEQ_DRIVE) begin
         mii_nxt = ~strap_r[PIN_MODE_COL];
         serial_nxt = strap_r[PIN_MODE_COL] & ~spd_s2_r;
         symbol_nxt = strap_r[PIN_MODE_COL] & spd_s2_r;
      end
   end

   // Pin drive and mode outputs.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         out_r <= '0;
         mii_r <= 1'b0;
         serial_r <= 1'b0;
         symbol_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
         mii_r <= mii_nxt;
         serial_r <= serial_nxt;
         symbol_r <= symbol_nxt;
      end
   end

   // Word-aligned decode used by both the read and the write path.
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // Status word gathers the block's own state for software.
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[ST_MODE_STRAP] = strap_r[PIN_MODE_COL];
      status_word[ST_ADDR2] = strap_r[PIN_ADDR2_LINK];
      status_word[ST_ADDR3] = strap_r[PIN_ADDR3_TX];
      status_word[ST_SPEED] = spd_s2_r;
      status_word[ST_COL_LED] = col_active;
      status_word[ST_LINK] = link_ok;
      status_word[ST_DRIVING] = (seq_r == SEQ_DRIVE);
   end

   // Avalon slave: one wait cycle, then a single cycle with waitrequest low completes the access.
   always_comb begin
      acc_ok = (avs_read || avs_write) && !wait_r;
      wait_nxt = 1'b1;
      rdata_nxt = rdata_r;
      control_nxt = control_r;
      soft_rst_nxt = 1'b0;
      if ((avs_read || avs_write) && wait_r) begin
         wait_nxt = 1'b0;
         rdata_nxt = 32'h0000_0000;
         if (avs_read && hit(avs_address, OFS_STATUS)) begin
            rdata_nxt = status_word;
         end else if (avs_read && hit(avs_address, OFS_CONTROL)) begin
            rdata_nxt = control_r;
         end
      end
      if (acc_ok && avs_write && hit(avs_address, OFS_CONTROL)) begin
         control_nxt = 32'h0000_0000;
         control_nxt[CT_LED_OFF] = avs_writedata[CT_LED_OFF];
         soft_rst_nxt = avs_writedata[CT_SOFT_RESET];
      end
   end

   // Bus and control registers.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wait_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
         control_r <= CONTROL_RST;
         soft_rst_r <= 1'b0;
      end else begin
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
         control_r <= control_nxt;
         soft_rst_r <= soft_rst_nxt;
      end
   end

   assign pad_out = out_r;
   assign pad_oe = oe_r;
   assign iface_mii = mii_r;
   assign iface_serial = serial_r;
   assign iface_symbol = symbol_r;
   assign station_addr2 = strap_r[PIN_ADDR2_LINK];
   assign station_addr3 = strap_r[PIN_ADDR3_TX];
   assign strap_valid = oe_r[PIN_MODE_COL];
   assign avs_readdata = rdata_r;
   assign avs_waitrequest = wait_r;
endmodule : ssl_strap_led
`default_nettype wire

// [bench/ssl_board.sv]
// Board model: pull resistors with series LEDs on the three strap pins.
`timescale 1ns/1ps
`default_nettype none
module ssl_board (
   input wire logic [2:0] pull,
   input wire logic [2:0] pad_out,
   input wire logic [2:0] pad_oe,
   output logic [2:0] pad_in
);
   // An undriven pin settles to its pull level, so a strap is never left floating.
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         pad_in[k] = pad_oe[k] ? pad_out[k] : pull[k];
      end
   end
endmodule : ssl_board
`default_nettype wire

// [bench/ssl_strap_led_sva.sv]
// Concurrent checks on the strap pins and status outputs.
`timescale 1ns/1ps
`default_nettype none
module ssl_strap_led_chk
   import ssl_pkg::*;
#(
   parameter int COL_HOLD = 20
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [STRAP_W-1:0] pad_out,
   input wire logic [STRAP_W-1:0] pad_oe,
   input wire logic collision_det,
   input wire logic link_ok,
   input wire logic iface_mii,
   input wire logic iface_serial,
   input wire logic iface_symbol,
   input wire logic station_addr2,
   input wire logic station_addr3,
   input wire logic strap_valid,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Wide enough that the saturated value always lies beyond the end of the hold.
   localparam int CW = $clog2(COL_HOLD + 4);
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic led_off_r;
   logic soft_r;
   logic soft_clr_r;
   logic ctl_wr;
   // A control write takes effect at the edge where waitrequest is seen low.
   assign ctl_wr = avs_write && !avs_waitrequest && (avs_address == OFS_CONTROL);
   // Cycles since the last collision; it saturates so a quiet line reads as long ago.
   // A soft reset ends the hold two edges after its write unless a new collision comes first.
   always_comb begin
      cnt_nxt = (cnt_r == '1) ? cnt_r : cnt_r + CW'(1);
      if (soft_clr_r) begin
         cnt_nxt = '1;
      end
      if (collision_det && strap_valid) begin
         cnt_nxt = CW'(1);
      end
   end
   // Helper state mirrors the control register so the pin checks know when the LEDs are forced off.
   always_ff @(posedge clk_sys) begin
      cnt_r <= reset_n ? cnt_nxt : '1;
      led_off_r <= reset_n && (ctl_wr ? avs_writedata[CT_LED_OFF] : led_off_r);
      soft_r <= reset_n && ctl_wr && avs_writedata[CT_SOFT_RESET];
      soft_clr_r <= reset_n && soft_r && !(collision_det && strap_valid);
   end
   property p_oe_seq;
      $rose(reset_n) |-> pad_oe == 3'h0 ##1 pad_oe == 3'h0 ##1 pad_oe == 3'h7;
   endproperty
   a_oe_seq: assert property (p_oe_seq) else $error("pins not released then driven");
   property p_oe_hold;
      strap_valid |-> pad_oe == 3'h7;
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("pins stopped driving");
   property p_addr;
      strap_valid && $past(strap_valid) |-> $stable(station_addr2) && $stable(station_addr3);
   endproperty
   a_addr: assert property (p_addr) else $error("station address moved");
   property p_link;
      strap_valid && $past(strap_valid)
         |-> pad_out[1] == (($past(link_ok) && !$past(led_off_r)) ? ~station_addr2 : station_addr2);
   endproperty
   a_link: assert property (p_link) else $error("link pin wrong");
   property p_tx;
      strap_valid && $past(strap_valid)
         |-> pad_out[2] == (($past(link_ok) && !$past(led_off_r)) ? ~station_addr3 : station_addr3);
   endproperty
   a_tx: assert property (p_tx) else $error("transmit pin wrong");
   property p_mode;
      strap_valid && $past(strap_valid, 2) |-> $onehot({iface_mii, iface_serial, iface_symbol});
   endproperty
   a_mode: assert property (p_mode) else $error("mode not one-hot");
   property p_col_on;
      strap_valid && $past(strap_valid, 2) && int'(cnt_r) >= 2 && int'(cnt_r) <= COL_HOLD + 1
         && !$past(led_off_r) |-> pad_out[0] == iface_mii;
   endproperty
   a_col_on: assert property (p_col_on) else $error("collision not held");
   property p_col_off;
      strap_valid && $past(strap_valid, 2) && int'(cnt_r) >= COL_HOLD + 2 |-> pad_out[0] != iface_mii;
   endproperty
   a_col_off: assert property (p_col_off) else $error("collision held too long");
   property p_led_off;
      strap_valid && $past(strap_valid) && $past(led_off_r) |-> pad_out[0] != iface_mii;
   endproperty
   a_led_off: assert property (p_led_off) else $error("indicator not forced off");
   c_col: cover property (collision_det && strap_valid);
   c_link: cover property ($rose(link_ok) && strap_valid);
   c_soft: cover property (avs_write && !avs_waitrequest && avs_address == OFS_CONTROL);
   c_led: cover property (led_off_r && link_ok);
endmodule : ssl_strap_led_chk
bind ssl_strap_led ssl_strap_led_chk #(.COL_HOLD(COL_HOLD)) i_chk (.clk_sys(clk_sys), .reset_n(reset_n),
   .pad_out(pad_out), .pad_oe(pad_oe), .collision_det(collision_det), .link_ok(link_ok),
   .iface_mii(iface_mii), .iface_serial(iface_serial), .iface_symbol(iface_symbol),
   .station_addr2(station_addr2), .station_addr3(station_addr3), .strap_valid(strap_valid),
   .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the strap and status LED block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ssl_pkg::*;
   localparam int HOLD = 20;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic speed_select = 1'b0;
   logic collision_det = 1'b0;
   logic link_ok = 1'b0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [ADDR_W-1:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [2:0] pull = 3'h0;
   logic [2:0] pad_in, pad_out, pad_oe;
   logic iface_mii, iface_serial, iface_symbol, station_addr2, station_addr3, strap_valid, avs_waitrequest;
   logic [31:0] avs_readdata, rd;
   logic [31:0] seed = 32'h3edb6e78;
   int mismatches = 0;
   int check_count = 0;
   int gap;
   // Half period of 4 ns gives the 125 MHz clock.
   always #4 clk_sys = ~clk_sys;
   ssl_strap_led #(.COL_HOLD(HOLD)) i_ssl_strap_led (.clk_sys(clk_sys), .reset_n(reset_n), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .speed_select(speed_select), .collision_det(collision_det),
      .link_ok(link_ok), .iface_mii(iface_mii), .iface_serial(iface_serial), .iface_symbol(iface_symbol),
      .station_addr2(station_addr2), .station_addr3(station_addr3), .strap_valid(strap_valid),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   ssl_board i_ssl_board (.pull(pull), .pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic final_report;
      if (mismatches == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
   endtask : tick
   // One bus access; the request stands until waitrequest is seen low, and only the watchdog ends a hang.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0);
      chk("wait_cycles", 32'h2, 32'(n));
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic pulse;
      collision_det <= 1'b1;
      @(posedge clk_sys);
      collision_det <= 1'b0;
   endtask : pulse
   // Every strap pattern once, with a random speed and collision spacing.
   initial begin
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         pull <= i[2:0];
         speed_select <= seed[0];
         link_ok <= 1'b0;
         reset_n <= 1'b0;
         tick(5);
         reset_n <= 1'b1;
         tick(6);
         chk("addr", 32'(i[2:1]), 32'({station_addr3, station_addr2}));
         chk("mode", 32'({~i[0], i[0] & ~seed[0], i[0] & seed[0]}), 32'({iface_mii, iface_serial, iface_symbol}));
         chk("oe", 32'h7, 32'(pad_oe));
         chk("valid", 32'h1, 32'(strap_valid));
         chk("idle", 32'(i[2:0]), 32'(pad_out));
         link_ok <= 1'b1;
         tick(3);
         chk("link", 32'(i[2:1]), 32'(pad_out[2:1] ^ 2'h3));
         pulse();
         tick(3);
         chk("col", 32'(i[0]), 32'(pad_out[0] ^ 1'b1));
         gap = 10 + int'(seed[3:1]);
         tick(gap);
         pulse();
         tick(gap);
         chk("restart", 32'(i[0]), 32'(pad_out[0] ^ 1'b1));
         tick(HOLD);
         chk("expire", 32'(i[0]), 32'(pad_out[0]));
         // A soft reset in the middle of a hold ends it, while straps and drive stay as they were.
         pull <= ~i[2:0];
         pulse();
         bus(1'b1, OFS_CONTROL, 32'h1);
         tick(4);
         chk("col_clear", 32'(i[0]), 32'(pad_out[0]));
         bus(1'b0, OFS_STATUS, 32'h0);
         chk("status", 32'({2'b11, 1'b0, seed[0], i[2:0]}), 32'(rd[6:0]));
         chk("oe_soft", 32'h7, 32'(pad_oe));
         bus(1'b0, 4'h8, 32'h0);
         chk("unmapped", 32'h0, rd);
         // Forcing the LEDs off leaves every pin at its strap level although the link is up.
         bus(1'b1, OFS_CONTROL, 32'h2);
         tick(3);
         chk("led_off", 32'(i[2:0]), 32'(pad_out));
         bus(1'b0, OFS_CONTROL, 32'h0);
         chk("control", 32'h2, rd);
      end
      final_report();
   end
   // A hang is cut short well beyond the fewer than 800 cycles the run needs.
   initial begin
      tick(20000);
      mismatches++;
      final_report();
   end
endmodule : testbench
`default_nettype wire
